//--- bench/pemux_chk_sva.sv
`timescale 1ns/1ps
module pemux_chk (
    // clock and reset
    input  wire logic       mclk_i,
    input  wire logic       rstn_i,
    // register port
    input  wire logic       reg_rd_i,
    input  wire logic [7:0] reg_rdata_o,
    // pads and memory bus
    input  wire logic [5:0] pin_in_i,
    input  wire logic [5:0] pin_out_o,
    input  wire logic [5:0] pin_oen_o,
    input  wire logic       membus_active_i,
    input  wire logic       membus_read_i,
    input  wire logic [5:0] membus_addr_data_i,
    input  wire logic [5:0] membus_data_o,
    // slave strobes
    input  wire logic       slave_rd_n_o,
    input  wire logic       slave_wr_n_o,
    input  wire logic       slave_sel_n_o
);
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);

    // memory bus ownership of the pads
    a_membus_drv: assert property (membus_active_i && !membus_read_i |=>
        pin_oen_o == 6'h00 && pin_out_o == $past(membus_addr_data_i))
        else $error("pads not on memory bus");
    a_membus_rd: assert property (membus_active_i && membus_read_i |=>
        pin_oen_o == 6'h3f && membus_data_o == $past(pin_in_i))
        else $error("memory bus read not sampled");
    a_membus_hold: assert property (!(membus_active_i && membus_read_i) |=>
        $stable(membus_data_o)) else $error("read data moved");
    a_membus_wins: assert property (membus_active_i |=>
        slave_rd_n_o && slave_wr_n_o && slave_sel_n_o) else $error("strobe under bus");
    // strobes copy the pins one cycle late
    a_rd_strobe: assert property (!slave_rd_n_o |->
        !$past(pin_in_i[0]) && !$past(membus_active_i)) else $error("bad read strobe");
    a_wr_strobe: assert property (!slave_wr_n_o |->
        !$past(pin_in_i[1]) && !$past(membus_active_i)) else $error("bad write strobe");
    a_sel_strobe: assert property (!slave_sel_n_o |->
        !$past(pin_in_i[2]) && !$past(membus_active_i)) else $error("bad select");
    // reset and read data
    a_reset_float: assert property (disable iff (1'b0)
        !rstn_i |-> pin_oen_o == 6'h3f) else $error("pad driven in reset");
    a_rdata_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("read data without strobe");
    c_bus_read: cover property (membus_active_i && membus_read_i);
    c_wr_strobe: cover property (!slave_wr_n_o);
    c_port_mix: cover property (pin_oen_o == 6'h03);
    c_part_float: cover property (pin_oen_o == 6'h20);
endmodule

bind pemux_top pemux_chk u_chk (
    .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
    .pin_in_i(pin_in_i), .pin_out_o(pin_out_o), .pin_oen_o(pin_oen_o),
    .membus_active_i(membus_active_i), .membus_read_i(membus_read_i),
    .membus_addr_data_i(membus_addr_data_i), .membus_data_o(membus_data_o),
    .slave_rd_n_o(slave_rd_n_o), .slave_wr_n_o(slave_wr_n_o), .slave_sel_n_o(slave_sel_n_o)
);

//--- bench/pemux_host.sv
`timescale 1ns/1ps
module pemux_host (
    // clock
    input  wire logic       mclk_i,
    // device pads
    input  wire logic [5:0] pin_out_i,
    input  wire logic [5:0] pin_oen_i,
    // host drive
    input  wire logic [5:0] host_en_i,
    input  wire logic [5:0] host_lvl_i,
    // resolved levels
    output logic      [5:0] pin_in_o
);
    logic [5:0] flt = 6'h15;

    // released lines flip so a stale level never passes
    always @(posedge mclk_i) begin
        flt <= ~flt;
    end

    // host strobes
    // host drives strobes and data only where the device let go
    assign pin_in_o = (~pin_oen_i & pin_out_i) | (pin_oen_i & host_en_i & host_lvl_i)
                    | (pin_oen_i & ~host_en_i & flt);
endmodule

//--- bench/test_port_e_pin_function_mux.sv
`timescale 1ns/1ps
`include "pemux_params.svh"
module test_port_e_pin_function_mux;
    logic       mclk_i = 1'b0;
    logic       rstn_i = 1'b1;
    logic [2:0] reg_addr_i = 3'h0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic       reg_wr_i = 1'b0;
    logic       reg_rd_i = 1'b0;
    logic [7:0] reg_rdata_o;
    logic [5:0] pin_in_i;
    logic [5:0] pin_out_o;
    logic [5:0] pin_oen_o;
    logic [5:0] membus_data_o;
    logic       membus_active_i = 1'b0;
    logic       membus_read_i = 1'b0;
    logic [5:0] membus_addr_data_i = 6'h00;
    logic       slave_rd_n_o;
    logic       slave_wr_n_o;
    logic       slave_sel_n_o;
    logic [5:0] pwm_lvl = 6'h00;
    logic [5:0] pwm_chan_en_i = 6'h00;
    logic [2:0] pwm_shutdown_i = 3'h0;
    logic [5:0] host_en = 6'h00;
    logic [5:0] host_lvl = 6'h00;
    int         num_errors = 0;
    int         n_compared = 0;
    logic [7:0] strobes;

    // slave strobes gathered as {select, write, read}
    assign strobes = {5'h0, slave_sel_n_o, slave_wr_n_o, slave_rd_n_o};

    always #10 mclk_i = ~mclk_i;

    pemux_top DUT (
        .mclk_i(mclk_i), .rstn_i(rstn_i), .reg_addr_i(reg_addr_i),
        .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
        .reg_rdata_o(reg_rdata_o), .pin_in_i(pin_in_i), .pin_out_o(pin_out_o),
        .pin_oen_o(pin_oen_o), .membus_active_i(membus_active_i),
        .membus_read_i(membus_read_i), .membus_addr_data_i(membus_addr_data_i),
        .membus_data_o(membus_data_o), .slave_rd_n_o(slave_rd_n_o),
        .slave_wr_n_o(slave_wr_n_o), .slave_sel_n_o(slave_sel_n_o),
        .pwm2_channel_d_i(pwm_lvl[0]), .pwm2_channel_c_i(pwm_lvl[1]),
        .pwm2_channel_b_i(pwm_lvl[2]), .pwm3_channel_c_i(pwm_lvl[3]),
        .pwm3_channel_b_i(pwm_lvl[4]), .pwm1_channel_c_i(pwm_lvl[5]),
        .pwm_chan_en_i(pwm_chan_en_i), .pwm_shutdown_i(pwm_shutdown_i)
    );

    pemux_host u_host (
        .mclk_i(mclk_i), .pin_out_i(pin_out_o), .pin_oen_i(pin_oen_o),
        .host_en_i(host_en), .host_lvl_i(host_lvl), .pin_in_o(pin_in_i)
    );

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        reg_addr_i  <= a;
        reg_wdata_i <= d;
        reg_wr_i    <= 1'b1;
        @(posedge mclk_i);
        reg_wr_i    <= 1'b0;
    endtask

    task automatic rd(input logic [2:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        reg_addr_i <= a;
        reg_rd_i   <= 1'b1;
        @(posedge mclk_i);
        reg_rd_i   <= 1'b0;
        #1 chk(reg_rdata_o, exp);
    endtask

    // let the one-stage pad mux catch up
    task automatic settle;
        repeat (3) @(posedge mclk_i);
        #1;
    endtask

    task automatic close_out;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // watchdog well beyond the run length
    initial begin
        #60000;
        num_errors++;
        close_out;
    end

    initial begin
        // falling edge after every process waits, so the async reset fires
        rstn_i <= 1'b0;
        repeat (10) @(posedge mclk_i);
        rstn_i <= 1'b1;
        #1 chk({2'h0, pin_oen_o}, 8'h3f);
        rd(`PEMUX_OFF_DIR, 8'h3f);
        rd(`PEMUX_OFF_LATCH, 8'h00);
        rd(`PEMUX_OFF_CTRL, 8'h0e);
        // port write lands in the latch, read gives pad levels
        wr(`PEMUX_OFF_LEVEL, 8'h2a);
        rd(`PEMUX_OFF_LATCH, 8'h2a);
        @(posedge mclk_i);
        host_en  <= 6'h03;
        host_lvl <= 6'h01;
        wr(`PEMUX_OFF_DIR, 8'h03);
        settle;
        chk({2'h0, pin_oen_o}, 8'h03);
        chk({2'h0, pin_out_o & 6'h3c}, 8'h28);
        rd(`PEMUX_OFF_LEVEL, 8'h29);
        // pwm beats latch on every pin, only with direction cleared
        wr(`PEMUX_OFF_DIR, 8'h00);
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk_i);
            pwm_chan_en_i <= 6'h3f;
            pwm_lvl       <= i ? 6'h0f : 6'h15;
            settle;
            chk({2'h0, pin_out_o}, i ? 8'h0f : 8'h15);
            chk({2'h0, pin_oen_o}, 8'h00);
        end
        wr(`PEMUX_OFF_DIR, 8'h3f);
        settle;
        chk({2'h0, pin_oen_o}, 8'h3f);
        // shutdown floats pwm pins only when so configured
        wr(`PEMUX_OFF_DIR, 8'h00);
        wr(`PEMUX_OFF_CTRL, 8'h7e);
        @(posedge mclk_i);
        pwm_shutdown_i <= 3'h7;
        settle;
        chk({2'h0, pin_oen_o}, 8'h3f);
        wr(`PEMUX_OFF_CTRL, 8'h0e);
        settle;
        chk({2'h0, pin_oen_o}, 8'h00);
        // second unit unrouted, float only for the first unit
        wr(`PEMUX_OFF_CTRL, 8'h1a);
        settle;
        chk({2'h0, pin_oen_o}, 8'h20);
        chk({2'h0, pin_out_o}, 8'h0a);
        @(posedge mclk_i);
        pwm_shutdown_i <= 3'h0;
        pwm_chan_en_i  <= 6'h00;
        // slave mode with direction left as outputs
        wr(`PEMUX_OFF_CTRL, 8'h0f);
        for (int i = 0; i < 2; i++) begin
            @(posedge mclk_i);
            host_en  <= 6'h07;
            host_lvl <= i ? 6'h02 : 6'h05;
            settle;
            chk({2'h0, pin_oen_o}, 8'h07);
            chk(strobes, i ? 8'h02 : 8'h05);
        end
        rd(`PEMUX_OFF_STATUS, 8'h02);
        // memory bus wins over slave mode and direction
        @(posedge mclk_i);
        membus_active_i    <= 1'b1;
        membus_addr_data_i <= 6'h2d;
        settle;
        chk({2'h0, pin_oen_o}, 8'h00);
        chk({2'h0, pin_out_o}, 8'h2d);
        chk(strobes, 8'h07);
        @(posedge mclk_i);
        membus_read_i <= 1'b1;
        host_en       <= 6'h3f;
        host_lvl      <= 6'h36;
        settle;
        chk({2'h0, pin_oen_o}, 8'h3f);
        chk({2'h0, membus_data_o}, 8'h36);
        @(posedge mclk_i);
        membus_active_i <= 1'b0;
        membus_read_i   <= 1'b0;
        settle;
        chk({2'h0, membus_data_o}, 8'h36);
        // unmapped and read-only places
        wr(3'h4, 8'hff);
        wr(3'h6, 8'hff);
        rd(3'h5, 8'h00);
        rd(`PEMUX_OFF_LATCH, 8'h2a);
        // second reset mid-run
        @(posedge mclk_i);
        rstn_i <= 1'b0;
        settle;
        chk({2'h0, pin_oen_o}, 8'h3f);
        @(posedge mclk_i);
        rstn_i <= 1'b1;
        rd(`PEMUX_OFF_DIR, 8'h3f);
        close_out;
    end
endmodule

//--- logic/pemux_params.svh
`ifndef PEMUX_PARAMS_SVH
`define PEMUX_PARAMS_SVH

// ----------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------
`define PEMUX_OFF_LEVEL     3'h0
`define PEMUX_OFF_LATCH     3'h1
`define PEMUX_OFF_DIR       3'h2
`define PEMUX_OFF_CTRL      3'h3
`define PEMUX_OFF_STATUS    3'h4

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PEMUX_RST_LATCH     6'h00
`define PEMUX_RST_DIR       6'h3f
`define PEMUX_RST_CTRL      7'h0e
`define PEMUX_RST_PINS      6'h00
`define PEMUX_RST_OEN       6'h3f
`define PEMUX_RST_STROBES   3'h7
`define PEMUX_RST_RDATA     8'h00

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define PEMUX_CTRL_SLAVE_MODE   0
`define PEMUX_CTRL_ROUTE_LSB    1
`define PEMUX_CTRL_TRI_LSB      4

// ----------------------------------------------------------------
// status register fields and pin counts
// ----------------------------------------------------------------
`define PEMUX_STAT_MEMBUS       0
`define PEMUX_STAT_DIR_FAULT    1
`define PEMUX_SLAVE_PINS        3

`endif

//--- logic/pemux_pkg.sv
package pemux_pkg;

    // what currently owns a pin
    typedef enum logic [2:0] {
        OWN_PORT_IN,
        OWN_PORT_OUT,
        OWN_MEMBUS_OUT,
        OWN_MEMBUS_IN,
        OWN_SLAVE_IN,
        OWN_PWM_DRIVE,
        OWN_PWM_TRI
    } pemux_owner_e;

    // pwm unit index
    typedef logic [1:0] pemux_unit_t;

endpackage

//--- logic/pemux_top.sv
`timescale 1ns/1ps
`include "pemux_params.svh"

// Function
// [RULE1] direction bit one: pin is input read back; zero: pin drives latch
// [RULE2] memory bus active: pins 0..5 drive address/data bits 8..13
// [RULE3] memory bus read: pins sample data bits 8..13, direction ignored
// [RULE4] slave port mode: pin 0 is host read strobe input
// [RULE5] slave port mode: pin 1 is host write strobe input
// [RULE6] slave port mode: pin 2 is host select input
// [RULE7] second pwm unit channels d, c, b routable to pins 0, 1, 2
// [RULE8] third pwm unit channel c on pin 3, channel b on pin 4
// [RULE9] first pwm unit channel c on pin 5 when pin is output
// [RULE10] enabled pwm channel beats latch and slave port data; the code beats the latch only, slave mode wins over pwm on pins 0..2
// [RULE11] pwm pin may float during its unit's shutdown event
// [RULE12] memory bus and slave port override the direction bits
// [RULE13] memory bus wins over every other pin function
// [RULE14] slave port mode bit alone turns pins 0..2 into control inputs
// [RULE15] after any reset every pin is a digital input
// [RULE16] port register reads pin levels; writes update the latch
module pemux_top #(
    parameter int PINS   = 6,
    parameter int AW     = 3,
    parameter int DW     = 8,
    parameter int UNITS  = 3
) (
    // clock and reset
    input  wire logic            mclk_i,
    input  wire logic            rstn_i,
    // register port
    input  wire logic [AW-1:0]   reg_addr_i,
    input  wire logic [DW-1:0]   reg_wdata_i,
    input  wire logic            reg_wr_i,
    input  wire logic            reg_rd_i,
    output logic      [DW-1:0]   reg_rdata_o,
    // pads
    input  wire logic [PINS-1:0] pin_in_i,
    output logic      [PINS-1:0] pin_out_o,
    output logic      [PINS-1:0] pin_oen_o,
    // external memory bus
    input  wire logic            membus_active_i,
    input  wire logic            membus_read_i,
    input  wire logic [PINS-1:0] membus_addr_data_i,
    output logic      [PINS-1:0] membus_data_o,
    // parallel slave port control, active low
    output logic                 slave_rd_n_o,
    output logic                 slave_wr_n_o,
    output logic                 slave_sel_n_o,
    // enhanced pwm channels
    input  wire logic            pwm2_channel_d_i,
    input  wire logic            pwm2_channel_c_i,
    input  wire logic            pwm2_channel_b_i,
    input  wire logic            pwm3_channel_c_i,
    input  wire logic            pwm3_channel_b_i,
    input  wire logic            pwm1_channel_c_i,
    input  wire logic [PINS-1:0] pwm_chan_en_i,
    input  wire logic [UNITS-1:0] pwm_shutdown_i
);

    // ------------------------------------------------------------
    // decoding helpers
    // ------------------------------------------------------------

    // pwm unit that serves a pin: 0 first, 1 second, 2 third
    function automatic pemux_pkg::pemux_unit_t unit_of_pin(input int idx);
        if (idx < 3) begin
            return 2'h1;
        end else if (idx < 5) begin
            return 2'h2;
        end else begin
            return 2'h0;
        end
    endfunction

    // register address match
    function automatic logic hit(input logic [AW-1:0] addr,
                                 input logic [AW-1:0] off);
        return addr == off;
    endfunction

    // ------------------------------------------------------------
    // software state
    // ------------------------------------------------------------
    logic [PINS-1:0]  out_latch;
    logic [PINS-1:0]  port_direction_bits;
    logic [6:0]       ctrl;
    logic [PINS-1:0]  pin_level;
    logic             slave_port_mode_bit;
    logic [UNITS-1:0] route_en;
    logic [UNITS-1:0] tri_on_shutdown;
    logic             dir_fault;

    // per-pin mux results
    pemux_pkg::pemux_owner_e owner [PINS];
    logic [PINS-1:0]  next_pin_out;
    logic [PINS-1:0]  next_pin_oen;
    logic [PINS-1:0]  pwm_level;

    assign slave_port_mode_bit = ctrl[`PEMUX_CTRL_SLAVE_MODE];
    assign route_en            = ctrl[`PEMUX_CTRL_ROUTE_LSB +: UNITS];
    assign tri_on_shutdown     = ctrl[`PEMUX_CTRL_TRI_LSB +: UNITS];

    // [RULE7] second unit routing
    // pins 0..2 take channels d, c, b of the second unit
    assign pwm_level[0] = pwm2_channel_d_i;
    assign pwm_level[1] = pwm2_channel_c_i;
    assign pwm_level[2] = pwm2_channel_b_i;
    // [RULE8] third unit routing
    // pins 3..4 take channels c, b of the third unit
    assign pwm_level[3] = pwm3_channel_c_i;
    assign pwm_level[4] = pwm3_channel_b_i;
    // [RULE9] first unit routing
    // pin 5 takes channel c of the first unit
    assign pwm_level[5] = pwm1_channel_c_i;

    // slave port mode with a control pin left as output
    assign dir_fault = slave_port_mode_bit
                     && (port_direction_bits[`PEMUX_SLAVE_PINS-1:0]
                         != {`PEMUX_SLAVE_PINS{1'b1}});

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------

    // output latch, written through the level or latch register
    // [RULE16] write updates latch
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            out_latch <= `PEMUX_RST_LATCH;
        end else if (reg_wr_i && (hit(reg_addr_i, `PEMUX_OFF_LEVEL)
                               || hit(reg_addr_i, `PEMUX_OFF_LATCH))) begin
            out_latch <= reg_wdata_i[PINS-1:0];
        end
    end

    // direction bits, all inputs out of reset
    // [RULE15] reset to inputs
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            port_direction_bits <= `PEMUX_RST_DIR;
        end else if (reg_wr_i && hit(reg_addr_i, `PEMUX_OFF_DIR)) begin
            port_direction_bits <= reg_wdata_i[PINS-1:0];
        end
    end

    // mode, routing and shutdown behaviour
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ctrl <= `PEMUX_RST_CTRL;
        end else if (reg_wr_i && hit(reg_addr_i, `PEMUX_OFF_CTRL)) begin
            ctrl <= reg_wdata_i[6:0];
        end
    end

    // ------------------------------------------------------------
    // pin sampling
    // ------------------------------------------------------------

    // pad levels as seen by software, whatever owns the pin
    // [RULE16] sampled pin levels
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_level <= `PEMUX_RST_PINS;
        end else begin
            pin_level <= pin_in_i;
        end
    end

    // incoming data bits 8..13 for the memory bus
    // [RULE3] membus read sample
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            membus_data_o <= `PEMUX_RST_PINS;
        end else if (membus_active_i && membus_read_i) begin
            membus_data_o <= pin_in_i;
        end
    end

    // slave port strobes, held inactive outside slave mode
    // or while the memory bus owns the pins
    // [RULE4] read strobe input
    // [RULE5] write strobe input
    // [RULE6] select input
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            {slave_sel_n_o, slave_wr_n_o, slave_rd_n_o} <= `PEMUX_RST_STROBES;
        end else if (slave_port_mode_bit && !membus_active_i) begin
            slave_rd_n_o  <= pin_in_i[0];
            slave_wr_n_o  <= pin_in_i[1];
            slave_sel_n_o <= pin_in_i[2];
        end else begin
            {slave_sel_n_o, slave_wr_n_o, slave_rd_n_o} <= `PEMUX_RST_STROBES;
        end
    end

    // ------------------------------------------------------------
    // per-pin ownership
    // ------------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            localparam pemux_pkg::pemux_unit_t UNIT = unit_of_pin(g);

            // pick the owner of pin g in priority order
            always_comb begin
                // [RULE13] membus first
                if (membus_active_i) begin
                    // [RULE2] drive address/data
                    // [RULE3] read cycle floats
                    // [RULE12] direction ignored
                    if (membus_read_i) begin
                        owner[g] = pemux_pkg::OWN_MEMBUS_IN;
                    end else begin
                        owner[g] = pemux_pkg::OWN_MEMBUS_OUT;
                    end
                // [RULE14] slave mode takes pins
                // [RULE12] slave overrides direction
                end else if (slave_port_mode_bit && (g < `PEMUX_SLAVE_PINS)) begin
                    owner[g] = pemux_pkg::OWN_SLAVE_IN;
                // [RULE10] pwm beats latch
                end else if (route_en[UNIT] && pwm_chan_en_i[g]
                             && !port_direction_bits[g]) begin
                    // [RULE11] float on shutdown
                    if (pwm_shutdown_i[UNIT] && tri_on_shutdown[UNIT]) begin
                        owner[g] = pemux_pkg::OWN_PWM_TRI;
                    end else begin
                        owner[g] = pemux_pkg::OWN_PWM_DRIVE;
                    end
                // [RULE1] direction bit
                end else if (!port_direction_bits[g]) begin
                    owner[g] = pemux_pkg::OWN_PORT_OUT;
                end else begin
                    owner[g] = pemux_pkg::OWN_PORT_IN;
                end
            end

            // level and enable for the chosen owner
            always_comb begin
                next_pin_out[g] = 1'b0;
                next_pin_oen[g] = 1'b1;
                case (owner[g])
                    pemux_pkg::OWN_MEMBUS_OUT: begin
                        next_pin_out[g] = membus_addr_data_i[g];
                        next_pin_oen[g] = 1'b0;
                    end
                    pemux_pkg::OWN_PWM_DRIVE: begin
                        next_pin_out[g] = pwm_level[g];
                        next_pin_oen[g] = 1'b0;
                    end
                    pemux_pkg::OWN_PORT_OUT: begin
                        next_pin_out[g] = out_latch[g];
                        next_pin_oen[g] = 1'b0;
                    end
                    default: begin
                        next_pin_out[g] = 1'b0;
                        next_pin_oen[g] = 1'b1;
                    end
                endcase
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // pad drivers
    // ------------------------------------------------------------

    // registered pad level and enable; low enable drives the pad
    // [RULE15] pads float in reset
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pin_out_o <= `PEMUX_RST_PINS;
            pin_oen_o <= `PEMUX_RST_OEN;
        end else begin
            pin_out_o <= next_pin_out;
            pin_oen_o <= next_pin_oen;
        end
    end

    // ------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------

    // read data stands one cycle after the read strobe, zero otherwise
    // [RULE16] read pin levels
    always_ff @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= `PEMUX_RST_RDATA;
        end else if (!reg_rd_i) begin
            reg_rdata_o <= `PEMUX_RST_RDATA;
        end else if (hit(reg_addr_i, `PEMUX_OFF_LEVEL)) begin
            reg_rdata_o <= DW'(pin_level);
        end else if (hit(reg_addr_i, `PEMUX_OFF_LATCH)) begin
            reg_rdata_o <= DW'(out_latch);
        end else if (hit(reg_addr_i, `PEMUX_OFF_DIR)) begin
            reg_rdata_o <= DW'(port_direction_bits);
        end else if (hit(reg_addr_i, `PEMUX_OFF_CTRL)) begin
            reg_rdata_o <= DW'(ctrl);
        end else if (hit(reg_addr_i, `PEMUX_OFF_STATUS)) begin
            reg_rdata_o <= DW'({dir_fault, membus_active_i});
        end else begin
            reg_rdata_o <= `PEMUX_RST_RDATA; // unmapped reads zero
        end
    end

endmodule
